// ==== tric_pkg.sv ====
// Register map, reset values and field positions of the ROI and integration configuration
package tric_pkg;
    localparam int       ADDR_W         = 8;
    localparam int       DATA_W         = 8;
    localparam int       LEN_W          = 16;
    localparam int       MULT_W         = 10;
    localparam int       MULT_HI_W      = 2;
    localparam int       EXPO_W         = 27;
    localparam int       ROW_REG_W      = 8;

    localparam logic [7:0] OFF_ROW_CTRL = 8'h92;
    localparam logic [7:0] OFF_MODE     = 8'h94;
    localparam logic [7:0] OFF_LX_HI    = 8'h96;
    localparam logic [7:0] OFF_LX_LO    = 8'h97;
    localparam logic [7:0] OFF_RX_HI    = 8'h98;
    localparam logic [7:0] OFF_RX_LO    = 8'h99;
    localparam logic [7:0] OFF_TOP_Y    = 8'h9A;
    localparam logic [7:0] OFF_BOT_Y    = 8'h9B;
    localparam logic [7:0] OFF_L2_HI    = 8'h9E;
    localparam logic [7:0] OFF_L2_LO    = 8'h9F;
    localparam logic [7:0] OFF_MUL_HI   = 8'hA0;
    localparam logic [7:0] OFF_MUL_LO   = 8'hA1;
    localparam logic [7:0] OFF_L1_HI    = 8'hA2;
    localparam logic [7:0] OFF_L1_LO    = 8'hA3;

    localparam logic [7:0] RST_ROW_CTRL = 8'h00;
    localparam logic [7:0] RST_MODE     = 8'h00;
    localparam logic [7:0] RST_LX_HI    = 8'h00;
    localparam logic [7:0] RST_LX_LO    = 8'h04;
    localparam logic [7:0] RST_RX_HI    = 8'h01;
    localparam logic [7:0] RST_RX_LO    = 8'h43;
    localparam logic [7:0] RST_TOP_Y    = 8'h06;
    localparam logic [7:0] RST_BOT_Y    = 8'h7D;
    localparam logic [7:0] RST_L2_HI    = 8'h07;
    localparam logic [7:0] RST_L2_LO    = 8'hFF;
    localparam logic [1:0] RST_MUL_HI   = 2'h0;
    localparam logic [7:0] RST_MUL_LO   = 8'h01;
    localparam logic [7:0] RST_L1_HI    = 8'h07;
    localparam logic [7:0] RST_L1_LO    = 8'hFF;

    localparam int       BIT_DUAL_MODE  = 7;
    localparam int       BIT_L2_ENABLE  = 3;

    localparam logic [7:0] READ_UNMAPPED = 8'h00;
endpackage : tric_pkg

// ==== tric_config.sv ====
// ROI and integration-time configuration register bank with exposure computation
// Summary of operation
// - Mode bit 7 clear selects standard full-resolution mode; set selects dual modes.
// - Four reset-initialised read/write coordinates bound the region of interest.
// - Second integration length counts periods of the second exposure; reset 2047.
// - Second length applies to even rows only while mode bit 7 and row control bit 3 are both set.
// - A 10-bit integration multiplier scales the lengths and resets to 1.
// - One multiplier serves both lengths; host never programs it below 1.
// - First integration length is 16 bits, reset 2047; host keeps it at 7 or more.
// - Exposure equals multiplier times length plus one, in modulation periods.
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
module tric_config
(
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    input  wire logic [7:0]   addr,
    input  wire logic [7:0]   wr_data,
    input  wire logic         wr_en,
    input  wire logic         rd_en,
    output logic      [7:0]   rd_data,
    output logic              dual_mode,
    output logic      [15:0]  roi_left_x,
    output logic      [15:0]  roi_right_x,
    output logic      [7:0]   roi_top_y,
    output logic      [7:0]   roi_bottom_y,
    output logic      [15:0]  first_length,
    output logic      [15:0]  second_length,
    output logic      [9:0]   exposure_multiplier,
    output logic      [15:0]  even_row_length,
    output logic      [26:0]  exposure_odd,
    output logic      [26:0]  exposure_even
);

    // Upper byte sits at the lower address
    function automatic logic [15:0] join_bytes(input logic [7:0] hi, input logic [7:0] lo);
        join_bytes = {hi, lo};
    endfunction : join_bytes

    // Exposure in modulation periods; 27 bits hold the largest product without wrap
    function automatic logic [26:0] expo(input logic [9:0] mul, input logic [15:0] len);
        logic [26:0] m;
        logic [26:0] l;
        m = {17'h00000, mul};
        l = {11'h000, len} + 27'h0000001;
        expo = 27'(m * l);
    endfunction : expo

    logic [7:0]  row_ctrl_reg,  row_ctrl_next;
    logic [7:0]  mode_reg,      mode_next;
    logic [7:0]  lx_hi_reg,     lx_hi_next;
    logic [7:0]  lx_lo_reg,     lx_lo_next;
    logic [7:0]  rx_hi_reg,     rx_hi_next;
    logic [7:0]  rx_lo_reg,     rx_lo_next;
    logic [7:0]  top_y_reg,     top_y_next;
    logic [7:0]  bot_y_reg,     bot_y_next;
    logic [7:0]  l2_hi_reg,     l2_hi_next;
    logic [7:0]  l2_lo_reg,     l2_lo_next;
    logic [1:0]  mul_hi_reg,    mul_hi_next;
    logic [7:0]  mul_lo_reg,    mul_lo_next;
    logic [7:0]  l1_hi_reg,     l1_hi_next;
    logic [7:0]  l1_lo_reg,     l1_lo_next;
    logic [7:0]  rd_data_reg,   rd_data_next;
    logic [15:0] even_len_reg,  even_len_next;
    logic [26:0] expo_odd_reg,  expo_odd_next;
    logic [26:0] expo_even_reg, expo_even_next;
    logic [15:0] len1_w;
    logic [15:0] len2_w;
    logic [9:0]  mul_w;

    assign len1_w = join_bytes(l1_hi_reg, l1_lo_reg);
    assign len2_w = join_bytes(l2_hi_reg, l2_lo_reg);
    assign mul_w  = {mul_hi_reg, mul_lo_reg};

    // Register writes
    always_comb
    begin
        row_ctrl_next = row_ctrl_reg;
        mode_next     = mode_reg;
        lx_hi_next    = lx_hi_reg;
        lx_lo_next    = lx_lo_reg;
        rx_hi_next    = rx_hi_reg;
        rx_lo_next    = rx_lo_reg;
        top_y_next    = top_y_reg;
        bot_y_next    = bot_y_reg;
        l2_hi_next    = l2_hi_reg;
        l2_lo_next    = l2_lo_reg;
        mul_hi_next   = mul_hi_reg;
        mul_lo_next   = mul_lo_reg;
        l1_hi_next    = l1_hi_reg;
        l1_lo_next    = l1_lo_reg;
        if (wr_en)
        begin
            case (addr)
                tric_pkg::OFF_ROW_CTRL: row_ctrl_next = wr_data;
                tric_pkg::OFF_MODE:     mode_next     = wr_data;
                tric_pkg::OFF_LX_HI:    lx_hi_next    = wr_data;
                tric_pkg::OFF_LX_LO:    lx_lo_next    = wr_data;
                tric_pkg::OFF_RX_HI:    rx_hi_next    = wr_data;
                tric_pkg::OFF_RX_LO:    rx_lo_next    = wr_data;
                tric_pkg::OFF_TOP_Y:    top_y_next    = wr_data;
                tric_pkg::OFF_BOT_Y:    bot_y_next    = wr_data;
                tric_pkg::OFF_L2_HI:    l2_hi_next    = wr_data;
                tric_pkg::OFF_L2_LO:    l2_lo_next    = wr_data;
                // Only ten multiplier bits exist; upper bits of the high byte are dropped
                tric_pkg::OFF_MUL_HI:   mul_hi_next   = wr_data[1:0];
                tric_pkg::OFF_MUL_LO:   mul_lo_next   = wr_data;
                tric_pkg::OFF_L1_HI:    l1_hi_next    = wr_data;
                tric_pkg::OFF_L1_LO:    l1_lo_next    = wr_data;
                default:                row_ctrl_next = row_ctrl_reg;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            row_ctrl_reg <= tric_pkg::RST_ROW_CTRL;
            mode_reg     <= tric_pkg::RST_MODE;
            lx_hi_reg    <= tric_pkg::RST_LX_HI;
            lx_lo_reg    <= tric_pkg::RST_LX_LO;
            rx_hi_reg    <= tric_pkg::RST_RX_HI;
            rx_lo_reg    <= tric_pkg::RST_RX_LO;
            top_y_reg    <= tric_pkg::RST_TOP_Y;
            bot_y_reg    <= tric_pkg::RST_BOT_Y;
            l2_hi_reg    <= tric_pkg::RST_L2_HI;
            l2_lo_reg    <= tric_pkg::RST_L2_LO;
            mul_hi_reg   <= tric_pkg::RST_MUL_HI;
            mul_lo_reg   <= tric_pkg::RST_MUL_LO;
            l1_hi_reg    <= tric_pkg::RST_L1_HI;
            l1_lo_reg    <= tric_pkg::RST_L1_LO;
        end
        else
        begin
            row_ctrl_reg <= row_ctrl_next;
            mode_reg     <= mode_next;
            lx_hi_reg    <= lx_hi_next;
            lx_lo_reg    <= lx_lo_next;
            rx_hi_reg    <= rx_hi_next;
            rx_lo_reg    <= rx_lo_next;
            top_y_reg    <= top_y_next;
            bot_y_reg    <= bot_y_next;
            l2_hi_reg    <= l2_hi_next;
            l2_lo_reg    <= l2_lo_next;
            mul_hi_reg   <= mul_hi_next;
            mul_lo_reg   <= mul_lo_next;
            l1_hi_reg    <= l1_hi_next;
            l1_lo_reg    <= l1_lo_next;
        end
    end

    // Read path and derived sequencer settings
    always_comb
    begin
        rd_data_next = tric_pkg::READ_UNMAPPED;
        if (rd_en)
        begin
            case (addr)
                tric_pkg::OFF_ROW_CTRL: rd_data_next = row_ctrl_reg;
                tric_pkg::OFF_MODE:     rd_data_next = mode_reg;
                tric_pkg::OFF_LX_HI:    rd_data_next = lx_hi_reg;
                tric_pkg::OFF_LX_LO:    rd_data_next = lx_lo_reg;
                tric_pkg::OFF_RX_HI:    rd_data_next = rx_hi_reg;
                tric_pkg::OFF_RX_LO:    rd_data_next = rx_lo_reg;
                tric_pkg::OFF_TOP_Y:    rd_data_next = top_y_reg;
                tric_pkg::OFF_BOT_Y:    rd_data_next = bot_y_reg;
                tric_pkg::OFF_L2_HI:    rd_data_next = l2_hi_reg;
                tric_pkg::OFF_L2_LO:    rd_data_next = l2_lo_reg;
                tric_pkg::OFF_MUL_HI:   rd_data_next = {6'h00, mul_hi_reg};
                tric_pkg::OFF_MUL_LO:   rd_data_next = mul_lo_reg;
                tric_pkg::OFF_L1_HI:    rd_data_next = l1_hi_reg;
                tric_pkg::OFF_L1_LO:    rd_data_next = l1_lo_reg;
                default:                rd_data_next = tric_pkg::READ_UNMAPPED;
            endcase
        end
        // Even rows use length 2 only in dual mode with the enable bit set
        if (mode_reg[tric_pkg::BIT_DUAL_MODE] && row_ctrl_reg[tric_pkg::BIT_L2_ENABLE])
        begin
            even_len_next = len2_w;
        end
        else
        begin
            even_len_next = len1_w;
        end
        // Same multiplier on both lengths; a zero multiplier simply yields zero exposure
        expo_odd_next  = expo(mul_w, len1_w);
        expo_even_next = expo(mul_w, even_len_next);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            rd_data_reg   <= tric_pkg::READ_UNMAPPED;
            even_len_reg  <= {tric_pkg::RST_L1_HI, tric_pkg::RST_L1_LO};
            expo_odd_reg  <= 27'h0000000;
            expo_even_reg <= 27'h0000000;
        end
        else
        begin
            rd_data_reg   <= rd_data_next;
            even_len_reg  <= even_len_next;
            expo_odd_reg  <= expo_odd_next;
            expo_even_reg <= expo_even_next;
        end
    end

    assign rd_data             = rd_data_reg;
    assign dual_mode           = mode_reg[tric_pkg::BIT_DUAL_MODE];
    assign roi_left_x          = join_bytes(lx_hi_reg, lx_lo_reg);
    assign roi_right_x         = join_bytes(rx_hi_reg, rx_lo_reg);
    assign roi_top_y           = top_y_reg;
    assign roi_bottom_y        = bot_y_reg;
    assign first_length        = len1_w;
    assign second_length       = len2_w;
    assign exposure_multiplier = mul_w;
    assign even_row_length     = even_len_reg;
    assign exposure_odd        = expo_odd_reg;
    assign exposure_even       = expo_even_reg;

    a_mode_bit_write: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (wr_en && addr == tric_pkg::OFF_MODE) |=> (dual_mode == $past(wr_data[7])))
        else $error("Mode bit did not follow write");

    a_roi_hold_value: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (!wr_en || (addr != tric_pkg::OFF_TOP_Y && addr != tric_pkg::OFF_BOT_Y))
        |=> $stable(roi_top_y) && $stable(roi_bottom_y))
        else $error("ROI Y changed without a write");

    a_len2_write_hi: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (wr_en && addr == tric_pkg::OFF_L2_HI) |=> (second_length[15:8] == $past(wr_data)))
        else $error("Second length high byte wrong");

    a_even_row_select: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (dual_mode && row_ctrl_reg[3]) |=> (even_row_length == $past(second_length)))
        else $error("Even rows not using second length");

    a_even_row_default: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        !(dual_mode && row_ctrl_reg[3]) |=> (even_row_length == $past(first_length)))
        else $error("Even rows not using first length");

    a_mult_width_ten: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (wr_en && addr == tric_pkg::OFF_MUL_HI) |=> (exposure_multiplier[9:8] == $past(wr_data[1:0])))
        else $error("Multiplier high bits wrong");

    a_mult_shared_both: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (first_length == second_length && dual_mode && row_ctrl_reg[3])
        ##1 $stable(exposure_multiplier) && $stable(first_length) && $stable(second_length)
        |=> (exposure_odd == exposure_even))
        else $error("Lengths equal but exposures differ");

    a_len1_byte_order: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (wr_en && addr == tric_pkg::OFF_L1_LO) |=> (first_length[7:0] == $past(wr_data)))
        else $error("First length low byte wrong");

    a_exposure_product: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        1'b1 |=> (exposure_odd ==
            27'($past(exposure_multiplier)) * (27'($past(first_length)) + 27'h0000001)))
        else $error("Exposure product wrong");

    a_read_one_cycle: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (rd_en && addr == tric_pkg::OFF_L1_HI) |=> (rd_data == $past(first_length[15:8])) ##1
        ($past(rd_en) || rd_data == 8'h00))
        else $error("Read data timing wrong");

endmodule : tric_config

// ==== tric_host.sv ====
// Host model that programs the configuration bank over its register port
`timescale 1ns/1ns
module tric_host
(
    input  wire logic       clk_sys,
    input  wire logic [7:0] rd_data,
    output logic      [7:0] addr,
    output logic      [7:0] wr_data,
    output logic            wr_en,
    output logic            rd_en
);
    initial
    begin
        addr    = 8'h00;
        wr_data = 8'h00;
        wr_en   = 1'b0;
        rd_en   = 1'b0;
    end

    // Released lines show inverted values, so a stale byte never looks valid
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clk_sys);
        wr_en   <= 1'b0;
        addr    <= ~a;
        wr_data <= ~d;
    endtask : write_reg

    // Read data stand only in the cycle after the strobe edge
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        addr  <= ~a;
        #1;
        d = rd_data;
    endtask : read_reg

    // Upper byte first, at the lower address
    task automatic write16(input logic [7:0] a, input logic [15:0] v);
        write_reg(a, v[15:8]);
        write_reg(a + 8'h01, v[7:0]);
    endtask : write16

    // Host side: multiplier never below 1, lengths never below 7, length plus one by 4
    task automatic program_exposure(input logic [15:0] mult, input logic [15:0] len1,
                                    input logic [15:0] len2);
        if (mult[9:0] != 10'h000 && len1 >= 16'h0007 && len2 >= 16'h0007
            && ((len1 + 16'h0001) & 16'h0003) == 16'h0000
            && ((len2 + 16'h0001) & 16'h0003) == 16'h0000)
        begin
            write16(8'hA0, mult);
            write16(8'hA2, len1);
            write16(8'h9E, len2);
        end
    endtask : program_exposure

    // Second length is only used once the host sets row control bit 3
    task automatic enable_even_rows();
        write_reg(8'h92, 8'h08);
    endtask : enable_even_rows
endmodule : tric_host

// ==== tric_config_bench.sv ====
// Self-checking bench for the ROI and integration configuration bank
`timescale 1ns/1ns
module tric_config_bench;
    logic        clk_sys;
    logic        rst_b;
    logic [7:0]  addr;
    logic [7:0]  wr_data;
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  rd_data;
    logic        dual_mode;
    logic [15:0] roi_left_x;
    logic [15:0] roi_right_x;
    logic [7:0]  roi_top_y;
    logic [7:0]  roi_bottom_y;
    logic [15:0] first_length;
    logic [15:0] second_length;
    logic [9:0]  exposure_multiplier;
    logic [15:0] even_row_length;
    logic [26:0] exposure_odd;
    logic [26:0] exposure_even;
    logic [7:0]  rd_seen;
    int          miscompares;
    int          samples_checked;
    int          cycles;
    localparam logic [7:0] REG_ADDR [14] = '{8'h92, 8'h94, 8'h96, 8'h97, 8'h98, 8'h99,
        8'h9A, 8'h9B, 8'h9E, 8'h9F, 8'hA0, 8'hA1, 8'hA2, 8'hA3};
    localparam logic [7:0] REG_RST [14] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h01, 8'h43,
        8'h06, 8'h7D, 8'h07, 8'hFF, 8'h00, 8'h01, 8'h07, 8'hFF};

    tric_config dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .dual_mode(dual_mode),
        .roi_left_x(roi_left_x), .roi_right_x(roi_right_x), .roi_top_y(roi_top_y),
        .roi_bottom_y(roi_bottom_y), .first_length(first_length),
        .second_length(second_length), .exposure_multiplier(exposure_multiplier),
        .even_row_length(even_row_length), .exposure_odd(exposure_odd),
        .exposure_even(exposure_even));

    tric_host host_u (.clk_sys(clk_sys), .rd_data(rd_data), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en));

    always #50 clk_sys = ~clk_sys;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    // Derived outputs lag a write by two cycles
    task automatic settle();
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : settle

    task automatic check_resets();
        for (int i = 0; i < 14; i++)
        begin
            host_u.read_reg(REG_ADDR[i], rd_seen);
            chk(rd_seen, REG_RST[i]);
        end
        chk(dual_mode, 1'b0);
        chk(roi_left_x, 16'h0004);
        chk(roi_right_x, 16'h0143);
        chk(second_length, 16'h07FF);
        chk(first_length, 16'h07FF);
        chk(even_row_length, 16'h07FF);
        chk(exposure_multiplier, 10'h001);
        chk(exposure_odd, 27'h0000800);
        chk(exposure_even, 27'h0000800);
    endtask : check_resets

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            conclude();
        end
    end

    initial
    begin
        clk_sys = 1'b0;
        rst_b = 1'b0;
        miscompares = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        check_resets();
        host_u.write_reg(8'h95, 8'h5A);
        host_u.read_reg(8'h95, rd_seen);
        chk(rd_seen, 8'h00);
        // Upper multiplier bits beyond 10 are not kept
        host_u.program_exposure(16'hFC03, 16'h0013, 16'h0017);
        settle();
        chk(exposure_multiplier, 10'h003);
        chk(first_length, 16'h0013);
        chk(second_length, 16'h0017);
        chk(exposure_odd, 27'h000003C);
        chk(exposure_even, 27'h000003C);
        host_u.read_reg(8'hA0, rd_seen);
        chk(rd_seen, 8'h00);
        // Row enable alone must not switch the even rows
        host_u.enable_even_rows();
        settle();
        chk(even_row_length, 16'h0013);
        host_u.write_reg(8'h94, 8'h80);
        settle();
        chk(dual_mode, 1'b1);
        chk(even_row_length, 16'h0017);
        chk(exposure_even, 27'h0000048);
        chk(exposure_odd, 27'h000003C);
        host_u.write16(8'h96, 16'h0123);
        host_u.write16(8'h98, 16'h0456);
        host_u.write_reg(8'h9A, 8'h10);
        host_u.write_reg(8'h9B, 8'h20);
        settle();
        chk(roi_left_x, 16'h0123);
        chk(roi_right_x, 16'h0456);
        chk(roi_top_y, 8'h10);
        chk(roi_bottom_y, 8'h20);
        host_u.read_reg(8'h98, rd_seen);
        chk(rd_seen, 8'h04);
        // Largest product must fit the exposure width
        host_u.program_exposure(16'h03FF, 16'hFFFF, 16'h0007);
        settle();
        chk(exposure_multiplier, 10'h3FF);
        chk(exposure_odd, 27'h3FF0000);
        chk(exposure_even, 27'h0001FF8);
        // Equal lengths in dual mode must give equal exposures
        host_u.program_exposure(16'h0002, 16'h000B, 16'h000B);
        settle();
        chk(exposure_odd, 27'h0000018);
        chk(exposure_even, 27'h0000018);
        @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        check_resets();
        conclude();
    end
endmodule : tric_config_bench
